//--- logic/event_log_pkg.sv
package event_log_pkg;

    // ************************************************************
    // Entry layout
    // ************************************************************
    localparam logic [7:0] platform_event_kind = 8'h00;
    localparam logic [7:0] vendor_timed_kind = 8'h01;
    localparam logic [7:0] vendor_plain_kind = 8'h02;
    localparam int KIND_BYTE = 0;
    localparam int LENGTH_BYTE = 1;
    localparam int HDR_BYTES = 2;
    localparam int UTC_BYTE = 0;
    localparam int SEC_FIRST_BYTE = 1;
    localparam int SEC_LAST_BYTE = 5;
    localparam int HUND_BYTE = 6;
    localparam int TS_BYTES = 7;
    localparam logic [7:0] UNSPEC_BYTE = 8'hFF;
    localparam int PCT_FULL = 100;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_REMOVE_COUNT = 8'h01;
    localparam logic [7:0] RST_THRESHOLD = 8'h08;
    localparam logic [31:0] RST_AGE_SEC = 32'h0000_0E10;
    localparam logic [7:0] RST_EID = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        pol_fill_stop = 2'h0,
        pol_fifo = 2'h1,
        pol_clear_age = 2'h2
    } policy_t;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_send = 2'h1,
        st_wait = 2'h3
    } stream_state_t;

endpackage

//--- logic/event_log_store.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Fill-and-stop with a full log rejects new entries, never overwrites.
// - Fill-and-stop never self-removes entries; only the clear command and acknowledged deliveries remove them.
// - FIFO policy on full: drop N oldest, then store the arriving entry.
// - N is configurable, optionally a percentage of log capacity.
// - Clear-on-age above M: if Nth oldest is too old, drop N oldest.
// - Clear-on-age at or below M keeps every entry regardless of age.
// - Clear-on-age uses age, N and M; N and M may be percentages.
// - The most recently selected policy and its parameters are applied.
// - Oldest and newest follow insertion order, never stored timestamps.
// - Entry byte zero is the entry kind code.
// - Entry byte one is the payload byte count.
// - Payload layout is chosen by the entry kind code.
// - Platform payload byte zero is UTC offset in half hours, FF unspecified.
// - Platform payload bytes one to five hold 40-bit epoch seconds.
// - Platform payload byte six holds hundredths, FF for one-second resolution.
// - Platform timestamp is followed by the event bytes as received.
// - Receiver location is the receiver endpoint identifier.
// - The manager delivers the receiver location; the terminus stores it.
// - A new receiver location is accepted at any time and used at once.
// - Entries leave by push or by polling from the receiver.
// - Nothing is sent before the receiver location is set.
module event_log_store #(
    parameter int DEPTH = 16,
    parameter int EVT_BYTES = 8,
    parameter int SEC_CYCLES = event_log_pkg::SECOND_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Entry intake.
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [7:0] log_entry_kind_i,
    input wire logic [7:0] utc_half_hour_offset_i,
    input wire logic [39:0] epoch_seconds_i,
    input wire logic [7:0] hundredths_of_second_i,
    input wire logic [EVT_BYTES*8-1:0] entry_payload_i,
    output logic wr_reject_o,
    // Policy and clear commands.
    input wire logic policy_set_i,
    input wire logic [1:0] policy_sel_i,
    input wire logic [7:0] removal_count_i,
    input wire logic removal_count_percent_i,
    input wire logic [7:0] threshold_i,
    input wire logic threshold_percent_i,
    input wire logic [31:0] age_seconds_i,
    input wire logic clear_log_i,
    // Receiver location.
    input wire logic rcv_set_i,
    input wire logic [7:0] rcv_eid_i,
    output logic [7:0] rcv_eid_o,
    output logic rcv_known_o,
    // Delivery stream.
    input wire logic push_mode_i,
    input wire logic poll_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [7:0] out_byte_o,
    output logic out_last_o,
    input wire logic ack_i,
    output logic ack_ready_o,
    // Status.
    output logic [$clog2(DEPTH):0] count_o,
    output logic full_o,
    output logic [1:0] policy_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int EW = EVT_BYTES * 8;

    // The five bit frame index caps the longest entry, hence the byte limit.
    if (DEPTH < 2 || DEPTH > 255 || (1 << AW) != DEPTH) begin
        $error("DEPTH must be a power of two from 2 to 128");
    end
    if (EVT_BYTES < 1 || EVT_BYTES > 16) begin
        $error("EVT_BYTES must be 1 to 16");
    end
    if (SEC_CYCLES < 2) begin
        $error("SEC_CYCLES must be at least 2");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [AW:0] to_entries(input logic [7:0] v,
                                               input logic pct,
                                               input int lo);
        int c;
        c = pct ? (DEPTH * int'(v)) / event_log_pkg::PCT_FULL : int'(v);
        if (c < lo)
            c = lo;
        if (c > DEPTH)
            c = DEPTH;
        return c[AW:0];
    endfunction

    function automatic logic [7:0] payload_len(input logic [7:0] kind);
        int n;
        n = EVT_BYTES;
        if (kind == event_log_pkg::platform_event_kind)
            n = event_log_pkg::TS_BYTES + EVT_BYTES;
        return n[7:0];
    endfunction

    function automatic logic [7:0] entry_byte(input logic [7:0] kind,
                                              input logic [7:0] utc,
                                              input logic [39:0] sec,
                                              input logic [7:0] hund,
                                              input logic [EW-1:0] ev,
                                              input logic [4:0] idx);
        logic [7:0] b;
        int p;
        b = 8'h00;
        p = int'(idx) - event_log_pkg::HDR_BYTES;
        if (int'(idx) == event_log_pkg::KIND_BYTE)
            b = kind;
        else if (int'(idx) == event_log_pkg::LENGTH_BYTE)
            b = payload_len(kind);
        else if (kind == event_log_pkg::platform_event_kind) begin
            if (p == event_log_pkg::UTC_BYTE)
                b = utc;
            else if (p <= event_log_pkg::SEC_LAST_BYTE)
                b = sec[(p - event_log_pkg::SEC_FIRST_BYTE) * 8 +: 8];
            else if (p == event_log_pkg::HUND_BYTE)
                b = hund;
            else if (p - event_log_pkg::TS_BYTES < EVT_BYTES)
                b = ev[(p - event_log_pkg::TS_BYTES) * 8 +: 8];
        end else if (p < EVT_BYTES)
            b = ev[p * 8 +: 8];
        return b;
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] kind_mem [DEPTH];
    logic [7:0] utc_mem [DEPTH];
    logic [39:0] sec_mem [DEPTH];
    logic [7:0] hund_mem [DEPTH];
    logic [EW-1:0] ev_mem [DEPTH];
    logic [31:0] stamp_mem [DEPTH];

    logic [AW-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
    logic [AW:0] count_ff, nxt_count;
    logic reject_ff, nxt_reject;
    event_log_pkg::policy_t policy_ff, nxt_policy;
    logic [7:0] n_raw_ff, nxt_n_raw, m_raw_ff, nxt_m_raw;
    logic n_pct_ff, nxt_n_pct, m_pct_ff, nxt_m_pct;
    logic [31:0] age_ff, nxt_age;
    logic [31:0] pre_ff, nxt_pre, sec_ff, nxt_sec;
    logic [7:0] eid_ff, nxt_eid;
    logic known_ff, nxt_known, poll_ff, nxt_poll;
    event_log_pkg::stream_state_t st_ff, nxt_st;
    logic [4:0] idx_ff, nxt_idx;
    logic [7:0] byte_ff, nxt_byte;
    logic last_ff, nxt_last;

    logic full, wr_fire, store, ack_fire, age_hit, start;
    logic [AW:0] n_eff, m_eff;
    logic [AW-1:0] nth_idx;

    // ************************************************************
    // Intake and clearing
    // ************************************************************
    always_comb begin
        full = count_ff == DEPTH[AW:0];
        n_eff = to_entries(n_raw_ff, n_pct_ff, 1);
        m_eff = to_entries(m_raw_ff, m_pct_ff, 0);
        // Deleting under a stream would pull the entry being sent away.
        wr_ready_o = !clear_log_i && !(full &&
            policy_ff == event_log_pkg::pol_fifo &&
            st_ff != event_log_pkg::st_idle);
        wr_fire = wr_valid_i && wr_ready_o;
        store = wr_fire && (!full || policy_ff == event_log_pkg::pol_fifo);
        ack_ready_o = st_ff == event_log_pkg::st_wait && !wr_valid_i &&
            !clear_log_i;
        ack_fire = ack_i && ack_ready_o;
        nth_idx = tail_ff + n_eff[AW-1:0] - 1'b1;
        age_hit = policy_ff == event_log_pkg::pol_clear_age &&
            st_ff == event_log_pkg::st_idle && !wr_valid_i &&
            !clear_log_i && count_ff > m_eff && count_ff >= n_eff &&
            (sec_ff - stamp_mem[nth_idx]) > age_ff;
    end

    always_comb begin
        nxt_head = head_ff;
        nxt_tail = tail_ff;
        nxt_count = count_ff;
        nxt_reject = 1'b0;
        if (clear_log_i) begin
            nxt_head = '0;
            nxt_tail = '0;
            nxt_count = '0;
        end else if (wr_fire) begin
            if (!full) begin
                nxt_head = head_ff + 1'b1;
                nxt_count = count_ff + 1'b1;
            end else if (policy_ff == event_log_pkg::pol_fifo) begin
                nxt_tail = tail_ff + n_eff[AW-1:0];
                nxt_head = head_ff + 1'b1;
                nxt_count = count_ff - n_eff + 1'b1;
            end else begin
                nxt_reject = 1'b1;
            end
        end else if (ack_fire) begin
            nxt_tail = tail_ff + 1'b1;
            nxt_count = count_ff - 1'b1;
        end else if (age_hit) begin
            nxt_tail = tail_ff + n_eff[AW-1:0];
            nxt_count = count_ff - n_eff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (store) begin
            kind_mem[head_ff] <= log_entry_kind_i;
            utc_mem[head_ff] <= utc_half_hour_offset_i;
            sec_mem[head_ff] <= epoch_seconds_i;
            hund_mem[head_ff] <= hundredths_of_second_i;
            ev_mem[head_ff] <= entry_payload_i;
            stamp_mem[head_ff] <= sec_ff;
        end
    end

    // ************************************************************
    // Policy, seconds and receiver location
    // ************************************************************
    always_comb begin
        nxt_policy = policy_ff;
        nxt_n_raw = n_raw_ff;
        nxt_n_pct = n_pct_ff;
        nxt_m_raw = m_raw_ff;
        nxt_m_pct = m_pct_ff;
        nxt_age = age_ff;
        if (policy_set_i) begin
            nxt_policy = event_log_pkg::policy_t'(policy_sel_i);
            nxt_n_raw = removal_count_i;
            nxt_n_pct = removal_count_percent_i;
            nxt_m_raw = threshold_i;
            nxt_m_pct = threshold_percent_i;
            nxt_age = age_seconds_i;
        end
        nxt_pre = pre_ff + 1'b1;
        nxt_sec = sec_ff;
        if (pre_ff == 32'(SEC_CYCLES - 1)) begin
            nxt_pre = '0;
            nxt_sec = sec_ff + 1'b1;
        end
        nxt_eid = eid_ff;
        nxt_known = known_ff;
        if (rcv_set_i) begin
            nxt_eid = rcv_eid_i;
            nxt_known = 1'b1;
        end
    end

    // ************************************************************
    // Delivery stream
    // ************************************************************
    always_comb begin
        start = st_ff == event_log_pkg::st_idle && count_ff != '0 &&
            known_ff && (push_mode_i || poll_ff) && !wr_valid_i &&
            !clear_log_i && !age_hit;
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_byte = byte_ff;
        nxt_last = last_ff;
        nxt_poll = poll_ff || poll_i;
        case (st_ff)
            event_log_pkg::st_idle: begin
                if (start) begin
                    nxt_st = event_log_pkg::st_send;
                    nxt_idx = '0;
                    nxt_last = 1'b0;
                    nxt_byte = entry_byte(kind_mem[tail_ff], utc_mem[tail_ff],
                        sec_mem[tail_ff], hund_mem[tail_ff], ev_mem[tail_ff],
                        5'h00);
                end
            end
            event_log_pkg::st_send: begin
                if (out_ready_i) begin
                    if (last_ff) begin
                        nxt_st = event_log_pkg::st_wait;
                    end else begin
                        nxt_idx = idx_ff + 1'b1;
                        nxt_last = {3'h0, nxt_idx} == 8'(payload_len(
                            kind_mem[tail_ff]) + 8'(event_log_pkg::HDR_BYTES)
                            - 8'h01);
                        nxt_byte = entry_byte(kind_mem[tail_ff],
                            utc_mem[tail_ff], sec_mem[tail_ff],
                            hund_mem[tail_ff], ev_mem[tail_ff], nxt_idx);
                    end
                end
            end
            event_log_pkg::st_wait: begin
                if (ack_fire) begin
                    nxt_st = event_log_pkg::st_idle;
                    nxt_poll = poll_i;
                end
            end
            default: nxt_st = event_log_pkg::st_idle;
        endcase
        if (clear_log_i)
            nxt_st = event_log_pkg::st_idle;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            head_ff <= '0;
            tail_ff <= '0;
            count_ff <= '0;
            reject_ff <= 1'b0;
            policy_ff <= event_log_pkg::pol_fill_stop;
            n_raw_ff <= event_log_pkg::RST_REMOVE_COUNT;
            n_pct_ff <= 1'b0;
            m_raw_ff <= event_log_pkg::RST_THRESHOLD;
            m_pct_ff <= 1'b0;
            age_ff <= event_log_pkg::RST_AGE_SEC;
            pre_ff <= '0;
            sec_ff <= '0;
            eid_ff <= event_log_pkg::RST_EID;
            known_ff <= 1'b0;
            poll_ff <= 1'b0;
            st_ff <= event_log_pkg::st_idle;
            idx_ff <= '0;
            byte_ff <= 8'h00;
            last_ff <= 1'b0;
        end else begin
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
            count_ff <= nxt_count;
            reject_ff <= nxt_reject;
            policy_ff <= nxt_policy;
            n_raw_ff <= nxt_n_raw;
            n_pct_ff <= nxt_n_pct;
            m_raw_ff <= nxt_m_raw;
            m_pct_ff <= nxt_m_pct;
            age_ff <= nxt_age;
            pre_ff <= nxt_pre;
            sec_ff <= nxt_sec;
            eid_ff <= nxt_eid;
            known_ff <= nxt_known;
            poll_ff <= nxt_poll;
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            byte_ff <= nxt_byte;
            last_ff <= nxt_last;
        end
    end

    assign wr_reject_o = reject_ff;
    assign rcv_eid_o = eid_ff;
    assign rcv_known_o = known_ff;
    assign out_valid_o = st_ff == event_log_pkg::st_send;
    assign out_byte_o = byte_ff;
    assign out_last_o = last_ff;
    assign count_o = count_ff;
    assign full_o = full;
    assign policy_o = policy_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start;
        st_ff == event_log_pkg::st_idle && nxt_st == event_log_pkg::st_send;
    endsequence

    sequence s_first_byte_taken;
        st_ff == event_log_pkg::st_send && idx_ff == 5'h00 && out_ready_i;
    endsequence

    a_full_rejects: assert property (
        policy_ff == event_log_pkg::pol_fill_stop && full && wr_fire
        |=> wr_reject_o && count_ff == $past(count_ff))
        else $error("full log did not reject an entry");
    a_no_self_clear: assert property (
        policy_ff == event_log_pkg::pol_fill_stop && !clear_log_i &&
        !ack_fire |=> count_ff >= $past(count_ff))
        else $error("fill and stop removed entries on its own");
    a_fifo_drop: assert property (
        policy_ff == event_log_pkg::pol_fifo && full && wr_fire
        |=> count_ff == DEPTH[AW:0] - $past(n_eff) + 1'b1)
        else $error("fifo policy removed the wrong count");
    a_pct_whole: assert property (
        n_pct_ff && n_raw_ff == 8'h64 |-> n_eff == DEPTH[AW:0])
        else $error("full percentage is not full capacity");
    a_age_clear: assert property (
        age_hit |=> count_ff == $past(count_ff) - $past(n_eff) &&
        tail_ff == $past(tail_ff) + $past(n_eff[AW-1:0]))
        else $error("aged entries not removed");
    a_below_keep: assert property (
        policy_ff == event_log_pkg::pol_clear_age && count_ff <= m_eff &&
        !wr_valid_i && !ack_fire && !clear_log_i
        |=> count_ff == $past(count_ff))
        else $error("entries removed below threshold");
    a_policy_load: assert property (
        policy_set_i |=> policy_ff == $past(policy_sel_i) &&
        age_ff == $past(age_seconds_i))
        else $error("policy command not applied");
    a_kind_byte: assert property (
        s_start |=> out_valid_o && out_byte_o == $past(kind_mem[tail_ff]))
        else $error("first byte is not the entry kind");
    a_length_byte: assert property (
        s_first_byte_taken |=> out_byte_o == payload_len(kind_mem[tail_ff]))
        else $error("second byte is not the payload length");
    a_eid_follow: assert property (
        rcv_set_i |=> rcv_eid_o == $past(rcv_eid_i) && rcv_known_o)
        else $error("receiver location not taken");
    a_no_send_unset: assert property (
        !known_ff |-> !out_valid_o)
        else $error("sent before receiver location was set");
    a_clear_empties: assert property (
        clear_log_i |=> count_ff == '0 && head_ff == '0 && tail_ff == '0)
        else $error("clear did not empty the log");

endmodule

`default_nettype wire

//--- test/event_receiver_model.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Receiver side of the delivery stream
// ************************************************************
module event_receiver_model (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Stream from the store.
    input wire logic out_valid_i,
    input wire logic out_last_i,
    input wire logic ack_ready_i,
    output logic out_ready_o,
    output logic ack_o
);
    int seed = 32'h33DE89E8;

    // Stalls one beat in four so that byte hold is exercised.
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ready_o <= 1'b0;
            ack_o <= 1'b0;
        end else begin
            out_ready_o <= (($random(seed) & 3) != 0);
            if (ack_o && ack_ready_i) begin
                ack_o <= 1'b0;
            end else if (out_valid_i && out_ready_o && out_last_i) begin
                ack_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
 err_total++; $display("[ERR] %s exp %0h got %0h", nm, (e), (g)); end end

module tb_top;
    localparam int D = 16;
    localparam int EB = 8;
    typedef struct {logic [7:0] k, u, h; logic [39:0] s; logic [63:0] p;} ent_t;
    logic clk = 1'b0, rst_n = 1'b0, wv = 1'b0, pset = 1'b0, rcp = 1'b0;
    logic thp = 1'b0, clr = 1'b0, rset = 1'b0, push = 1'b1, poll = 1'b0;
    logic [7:0] kind = 8'h00, utc = 8'h00, hund = 8'h00, rc = 8'h01;
    logic [7:0] th = 8'h08, reid = 8'h00;
    logic [39:0] sec = 40'h0;
    logic [63:0] pay = 64'h0;
    logic [1:0] psel = 2'h0;
    logic [31:0] age = 32'h0;
    logic wrdy, rej, known, oval, ordy, olast, ack, ackr, full;
    logic [7:0] reid_o, obyte;
    logic [4:0] cnt;
    logic [1:0] pol;
    int seed = 32'h33DE89E8;
    int err_total = 0, check_count = 0, mn = 1;
    bit mstop = 1'b1;
    ent_t mq[$];
    logic [7:0] got[$], eb[$];

    event_log_store #(.DEPTH(D), .EVT_BYTES(EB), .SEC_CYCLES(10)) DUT (
        .sys_clk_i(clk), .rst_n_i(rst_n), .wr_valid_i(wv),
        .wr_ready_o(wrdy), .log_entry_kind_i(kind),
        .utc_half_hour_offset_i(utc), .epoch_seconds_i(sec),
        .hundredths_of_second_i(hund), .entry_payload_i(pay),
        .wr_reject_o(rej), .policy_set_i(pset), .policy_sel_i(psel),
        .removal_count_i(rc), .removal_count_percent_i(rcp),
        .threshold_i(th), .threshold_percent_i(thp), .age_seconds_i(age),
        .clear_log_i(clr), .rcv_set_i(rset), .rcv_eid_i(reid),
        .rcv_eid_o(reid_o), .rcv_known_o(known), .push_mode_i(push),
        .poll_i(poll), .out_valid_o(oval), .out_ready_i(ordy),
        .out_byte_o(obyte), .out_last_o(olast), .ack_i(ack),
        .ack_ready_o(ackr), .count_o(cnt), .full_o(full), .policy_o(pol));

    event_receiver_model RCV (.sys_clk_i(clk), .rst_n_i(rst_n),
        .out_valid_i(oval), .out_last_i(olast), .ack_ready_i(ackr),
        .out_ready_o(ordy), .ack_o(ack));

    initial begin
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // Model of the stored byte image
    // ************************************************************
    function automatic void mk(input ent_t e, ref logic [7:0] b[$]);
        bit pf;
        pf = (e.k == event_log_pkg::platform_event_kind);
        b = {};
        b.push_back(e.k);
        b.push_back(pf ? 8'(7 + EB) : 8'(EB));
        if (pf) begin
            b.push_back(e.u);
            for (int i = 0; i < 5; i++) b.push_back(e.s[8*i+:8]);
            b.push_back(e.h);
        end
        for (int i = 0; i < EB; i++) b.push_back(e.p[8*i+:8]);
    endfunction

    always @(posedge clk) begin
        if (oval && ordy) begin
            got.push_back(obyte);
            if (olast) begin
                mk(mq[0], eb);
                `CHK("frame_len", eb.size(), got.size())
                for (int i = 0; i < eb.size() && i < got.size(); i++)
                    `CHK("byte", eb[i], got[i])
                got = {};
            end
        end
        if (ack && ackr) void'(mq.pop_front());
    end

    // ************************************************************
    // Driver tasks
    // ************************************************************
    task automatic put(input logic [7:0] k);
        ent_t e;
        logic ok;
        logic xr;
        e.k = k;
        e.u = 8'($random(seed));
        e.s = {8'($random(seed)), 32'($random(seed))};
        e.h = ($random(seed) & 1) ? 8'hFF : 8'($random(seed) & 32'h3F);
        e.p = {$random(seed), $random(seed)};
        @(posedge clk);
        kind <= e.k; utc <= e.u; sec <= e.s; hund <= e.h; pay <= e.p;
        wv <= 1'b1;
        do begin
            @(negedge clk);
            ok = wrdy;
            @(posedge clk);
        end while (ok !== 1'b1);
        wv <= 1'b0;
        xr = (mq.size() == D && mstop);
        if (!xr) begin
            if (mq.size() == D) repeat (mn) void'(mq.pop_front());
            mq.push_back(e);
        end
        @(negedge clk);
        `CHK("count", 5'(mq.size()), cnt)
        `CHK("reject", xr, rej)
        `CHK("full", 1'(mq.size() == D), full)
    endtask

    task automatic setpol(input logic [1:0] s, input logic [7:0] n,
                          input logic np, input logic [7:0] m);
        @(posedge clk);
        psel <= s; rc <= n; rcp <= np; th <= m; age <= 32'h1; pset <= 1'b1;
        @(posedge clk);
        pset <= 1'b0;
        @(negedge clk);
        `CHK("policy", s, pol)
    endtask

    task automatic clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        mq = {};
        @(negedge clk);
        `CHK("cleared", 5'h00, cnt)
    endtask

    task automatic wait_cnt(input int n);
        repeat (400) begin
            @(negedge clk);
            if (cnt === 5'(n)) break;
        end
        `CHK("drain", 5'(n), cnt)
    endtask

    task automatic set_rcv(input logic [7:0] id);
        @(posedge clk);
        reid <= id; rset <= 1'b1;
        @(posedge clk);
        rset <= 1'b0;
        @(negedge clk);
        `CHK("rcv_eid", id, reid_o)
        `CHK("rcv_known", 1'b1, known)
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(100 * 20000);
        err_total++;
        complete_run();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("count0", 5'h00, cnt)
        `CHK("known0", 1'b0, known)
        `CHK("policy0", 2'h0, pol)
        for (int i = 0; i <= D; i++) put(8'(i % 3));
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK("stop_keep", 5'(D), cnt)
        clear();
        setpol(2'h1, 8'h03, 1'b0, 8'h08);
        mn = 3;
        mstop = 1'b0;
        for (int i = 0; i <= D; i++) put(8'(i % 3));
        setpol(2'h1, 8'h19, 1'b1, 8'h08);
        mn = 4;
        repeat (3) put(8'h01);
        setpol(2'h2, 8'h02, 1'b0, 8'h04);
        clear();
        mstop = 1'b1;
        for (int i = 0; i < 4; i++) put(8'(i % 3));
        repeat (100) @(posedge clk);
        @(negedge clk);
        `CHK("age_keep", 5'h04, cnt)
        put(8'h00);
        repeat (100) @(posedge clk);
        repeat (2) void'(mq.pop_front());
        @(negedge clk);
        `CHK("age_drop", 5'h03, cnt)
        setpol(2'h1, 8'h64, 1'b1, 8'h08);
        set_rcv(8'h21);
        wait_cnt(0);
        set_rcv(8'h5A);
        @(posedge clk);
        push <= 1'b0;
        put(8'h00);
        put(8'h01);
        repeat (30) @(posedge clk);
        @(negedge clk);
        `CHK("no_poll", 5'h02, cnt)
        repeat (2) begin
            @(posedge clk);
            poll <= 1'b1;
            @(posedge clk);
            poll <= 1'b0;
            wait_cnt(mq.size() - 1);
        end
        complete_run();
    end
endmodule
`default_nettype wire
